// ===== fifo_status_consts.svh
// fixed numbers of the read port and status flag logic
// assumes inclusion by bare name from package and design files
`ifndef FIFO_STATUS_CONSTS_SVH
`define FIFO_STATUS_CONSTS_SVH
`define FIFO_DATA_W 9
`define FIFO_DEPTH 64
`define FIFO_AE_DEFAULT 7
`define FIFO_AF_DEFAULT 7
`define FIFO_BUF_ENTRIES 2
`endif

// ===== fifo_status_pkg.sv
// types shared by the read port and status flag logic
// assumes fifo_status_consts.svh on the include path
`include "fifo_status_consts.svh"
package fifo_status_pkg;
  // all four flags are active low, as on the pins
  typedef struct packed {
    logic full_n;
    logic almost_full_n;
    logic empty_n;
    logic almost_empty_n;
  } flags_s;
endpackage

// ===== fifo_read_port_and_status_flags.sv
// single-clock 9-bit fifo: storage, read port, three-state control, status flags
// assumes read and write sides share clk_sys and that DEPTH is a power of two
// What this block does
// R1 - read one word when both read enables low
// R2 - ignore read while empty flag is low
// R3 - drive output bus while output enable low
// R4 - release output bus while output enable high
// R5 - empty flag low when nothing stored, blocks reads
// R6 - empty flag high with data, clocked
// R7 - almost-empty low at or below its offset
// R8 - almost-empty offset seven after reset
// R9 - almost-empty flag updated on the clock
// R10 - almost-full low when free space at offset
// R11 - almost-full offset seven after reset
// R12 - almost-full flag updated on the clock
// R13 - full flag low when full, blocks writes
// R14 - full flag high with space, clocked
// R15 - reset clears pointers and sets flags
// R16 - outside party resets before first write
// R17 - store one word per enabled write edge
// R18 - cross pointers through synchronisers when clocks differ; not built here, clk_sys clocks both sides
`timescale 1ns/1ns
`default_nettype none
`include "fifo_status_consts.svh"
module fifo_read_port_and_status_flags
  import fifo_status_pkg::*;
#(
  parameter int DW = `FIFO_DATA_W,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [DW-1:0] write_data_in,
  input wire logic write_enable_a_n,
  input wire logic write_enable_b_or_offset_load,
  input wire logic offset_load,
  input wire logic [$clog2(DEPTH):0] ae_offset_in,
  input wire logic [$clog2(DEPTH):0] af_offset_in,
  input wire logic read_enable_a_n,
  input wire logic read_enable_b_n,
  input wire logic output_enable_n,
  output logic [DW-1:0] read_data_out,
  output logic read_data_oe,
  output logic full_indicator_n,
  output logic almost_full_indicator_n,
  output logic empty_indicator_n,
  output logic almost_empty_indicator_n
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] mem_cnt;
    logic [1:0] buf_cnt;
    logic [DW-1:0] buf0;
    logic [DW-1:0] buf1;
    logic [DW-1:0] q;
    logic [PW:0] ae_off;
    logic [PW:0] af_off;
    flags_s flags;
  } state_s;

  localparam state_s RESET_STATE = '{
    wr_ptr: '0, rd_ptr: '0, mem_cnt: '0, buf_cnt: 2'h0, buf0: '0, buf1: '0, q: '0,
    ae_off: (PW+1)'(`FIFO_AE_DEFAULT), af_off: (PW+1)'(`FIFO_AF_DEFAULT),
    flags: '{full_n: 1'b1, almost_full_n: 1'b1, empty_n: 1'b0, almost_empty_n: 1'b0}
  };

  function automatic logic at_or_below(input logic [PW:0] value, input logic [PW:0] limit);
    at_or_below = (value <= limit);
  endfunction

  logic [DW-1:0] mem [DEPTH];
  state_s s;
  state_s next_s;
  logic rd_req;
  logic rd_go;
  logic wr_go;
  logic fill_valid;
  logic fill_ready;
  logic fill_go;
  logic [1:0] cnt_after_pop;
  logic [PW:0] next_level;

  always_comb begin
    next_s = s;
    rd_req = !read_enable_a_n && !read_enable_b_n;
    // empty_n high implies the output buffer holds a word
    rd_go = rd_req && s.flags.empty_n; // R1 R2 R5
    wr_go = !write_enable_a_n && write_enable_b_or_offset_load && s.flags.full_n; // R13 R17
    cnt_after_pop = s.buf_cnt - {1'b0, rd_go};
    // two-entry buffer: drained by reads, filled from storage when room remains
    fill_valid = (s.mem_cnt != '0);
    fill_ready = (cnt_after_pop < 2'h2);
    fill_go = fill_valid && fill_ready;
    if (rd_go) begin
      next_s.q = s.buf0; // R1
      next_s.buf0 = s.buf1;
    end
    next_s.buf_cnt = cnt_after_pop;
    if (fill_go) begin
      if (cnt_after_pop == 2'h0) begin
        next_s.buf0 = mem[s.rd_ptr];
      end else begin
        next_s.buf1 = mem[s.rd_ptr];
      end
      next_s.buf_cnt = cnt_after_pop + 2'h1;
      next_s.rd_ptr = s.rd_ptr + 1'b1;
    end
    if (wr_go) begin
      next_s.wr_ptr = s.wr_ptr + 1'b1; // R17
    end
    next_s.mem_cnt = s.mem_cnt + (PW+1)'(wr_go) - (PW+1)'(fill_go);
    if (offset_load) begin
      next_s.ae_off = ae_offset_in;
      next_s.af_off = af_offset_in;
    end
    // full and both almost flags come from the next fill level so they change with the edge that causes them; empty comes from the next buffer count
    next_level = next_s.mem_cnt + (PW+1)'(next_s.buf_cnt);
    next_s.flags.empty_n = (next_s.buf_cnt != 2'h0); // R5 R6
    next_s.flags.almost_empty_n = !at_or_below(next_level, next_s.ae_off); // R7 R9
    next_s.flags.full_n = (next_level != (PW+1)'(DEPTH)); // R13 R14
    next_s.flags.almost_full_n =
      !at_or_below((PW+1)'(DEPTH) - next_level, next_s.af_off); // R10 R12
  end

  // one clock for both sides, so no pointer ever crosses a domain
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= RESET_STATE; // R15 R8 R11
    end else if (clk_en) begin
      s <= next_s; // R18
    end
  end

  // storage holds no reset; words are only readable once counted
  always_ff @(posedge clk_sys) begin
    if (clk_en && wr_go) begin
      mem[s.wr_ptr] <= write_data_in; // R17
    end
  end

  assign read_data_out = s.q; // R3
  assign read_data_oe = !output_enable_n; // R3 R4
  assign full_indicator_n = s.flags.full_n;
  assign almost_full_indicator_n = s.flags.almost_full_n;
  assign empty_indicator_n = s.flags.empty_n;
  assign almost_empty_indicator_n = s.flags.almost_empty_n;

  logic [PW:0] level;
  assign level = s.mem_cnt + (PW+1)'(s.buf_cnt);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  read_takes_word_a: assert property ( // R1
    clk_en && !read_enable_a_n && !read_enable_b_n && empty_indicator_n
    |=> read_data_out == $past(s.buf0) && s.buf_cnt <= $past(s.buf_cnt))
    else $error("read did not deliver the head word");
  empty_read_ignored_a: assert property ( // R2
    !empty_indicator_n && clk_en && !read_enable_a_n |=> $stable(read_data_out))
    else $error("read taken while empty");
  output_release_a: assert property ( // R4
    read_data_oe == !output_enable_n)
    else $error("output drive does not follow enable");
  empty_flag_a: assert property ( // R5
    empty_indicator_n == (s.buf_cnt != 2'h0))
    else $error("empty flag wrong");
  empty_clears_a: assert property ( // R6
    clk_en && s.mem_cnt != '0 && s.buf_cnt == 2'h0 |=> empty_indicator_n)
    else $error("empty flag not raised after prefetch");
  almost_empty_a: assert property ( // R7
    almost_empty_indicator_n == (level > s.ae_off))
    else $error("almost-empty flag wrong");
  almost_full_a: assert property ( // R10
    almost_full_indicator_n == (((PW+1)'(DEPTH) - level) > s.af_off))
    else $error("almost-full flag wrong");
  full_blocks_a: assert property ( // R13
    !full_indicator_n && !write_enable_a_n |=> $stable(s.wr_ptr))
    else $error("write taken while full");
  full_flag_a: assert property ( // R14
    full_indicator_n == (level != (PW+1)'(DEPTH)))
    else $error("full flag wrong");
  write_stores_a: assert property ( // R17
    clk_en && !write_enable_a_n && write_enable_b_or_offset_load && full_indicator_n
    |=> s.wr_ptr == $past(s.wr_ptr) + 1'b1)
    else $error("enabled write not stored");

  // reset state is checked while reset is held, so these override the disable
  reset_flags_a: assert property (disable iff (1'b0) // R15
    !rst_n |-> full_indicator_n && almost_full_indicator_n
      && !empty_indicator_n && !almost_empty_indicator_n)
    else $error("flags wrong while reset is held");

  reset_pointers_a: assert property (disable iff (1'b0) // R15
    !rst_n |-> s.wr_ptr == '0 && s.rd_ptr == '0 && level == '0)
    else $error("pointers not at first location in reset");

  reset_offsets_a: assert property (disable iff (1'b0) // R8 R11
    !rst_n |-> s.ae_off == (PW+1)'(`FIFO_AE_DEFAULT)
      && s.af_off == (PW+1)'(`FIFO_AF_DEFAULT))
    else $error("default offsets not restored by reset");

  reset_output_a: assert property (disable iff (1'b0) // R15
    !rst_n |-> read_data_out == '0)
    else $error("output word not cleared by reset");

  // a low clock enable must hold every bit of state, flags included
  freeze_state_a: assert property (
    !clk_en |=> $stable(s))
    else $error("state moved while clock enable low");

  freeze_flags_a: assert property ( // R9 R12
    !clk_en |=> $stable(empty_indicator_n) && $stable(almost_empty_indicator_n)
      && $stable(full_indicator_n) && $stable(almost_full_indicator_n))
    else $error("flag moved while clock enable low");

  // read side
  read_needs_both_a: assert property ( // R1
    clk_en && (read_enable_a_n || read_enable_b_n) |=> $stable(read_data_out))
    else $error("read taken without both enables");

  read_blocked_b_a: assert property ( // R2
    !empty_indicator_n && clk_en && !read_enable_b_n |=> $stable(read_data_out))
    else $error("read taken while empty");

  word_holds_a: assert property ( // R1
    clk_en && !rd_go |=> $stable(read_data_out))
    else $error("output word changed without a read");

  last_read_empties_a: assert property ( // R5
    clk_en && rd_go && s.buf_cnt == 2'h1 && s.mem_cnt == '0 |=> !empty_indicator_n)
    else $error("empty flag not lowered after last word");

  empty_stays_a: assert property ( // R5
    clk_en && !empty_indicator_n && s.mem_cnt == '0 |=> !empty_indicator_n)
    else $error("empty flag raised with nothing stored");

  rd_ptr_idle_a: assert property ( // R2
    s.mem_cnt == '0 |=> $stable(s.rd_ptr))
    else $error("read pointer moved with nothing stored");

  rd_ptr_step_a: assert property ( // R1
    clk_en && s.mem_cnt != '0 && s.buf_cnt == 2'h0
    |=> s.rd_ptr == $past(s.rd_ptr) + 1'b1)
    else $error("prefetch did not advance read pointer");

  buffer_bound_a: assert property (
    s.buf_cnt <= 2'(`FIFO_BUF_ENTRIES))
    else $error("output buffer overfilled");

  empty_level_a: assert property ( // R5 R7
    level == '0 |-> !empty_indicator_n && !almost_empty_indicator_n)
    else $error("empty buffer not flagged empty and almost empty");

  // write side
  write_needs_a_a: assert property ( // R17
    write_enable_a_n |=> $stable(s.wr_ptr))
    else $error("write taken with first enable high");

  write_needs_b_a: assert property ( // R17
    !write_enable_b_or_offset_load |=> $stable(s.wr_ptr))
    else $error("write taken with second enable low");

  full_level_a: assert property ( // R13
    level <= (PW+1)'(DEPTH))
    else $error("fill level above depth");

  last_write_fills_a: assert property ( // R13
    clk_en && wr_go && !rd_go && level == (PW+1)'(DEPTH - 1) |=> !full_indicator_n)
    else $error("full flag not lowered by last free location");

  full_stays_a: assert property ( // R13
    clk_en && !full_indicator_n && !rd_go |=> !full_indicator_n)
    else $error("full flag raised without a read");

  full_clears_a: assert property ( // R14
    clk_en && !full_indicator_n && !read_enable_a_n && !read_enable_b_n
    && empty_indicator_n |=> full_indicator_n)
    else $error("full flag not raised after a read");

  full_means_af_a: assert property ( // R10
    !full_indicator_n |-> !almost_full_indicator_n)
    else $error("full without almost full");

  // single clock: pointers and count always agree, nothing to resynchronise
  ptr_distance_a: assert property ( // R18
    s.wr_ptr - s.rd_ptr == s.mem_cnt[PW-1:0])
    else $error("pointer distance disagrees with stored count");

  mem_cnt_bound_a: assert property (
    s.mem_cnt <= (PW+1)'(DEPTH))
    else $error("storage count above depth");

  // fill level and offsets
  level_step_a: assert property ( // R1 R17
    clk_en |=> level == $past(level) + (PW+1)'($past(wr_go)) - (PW+1)'($past(rd_go)))
    else $error("fill level did not follow reads and writes");

  offset_load_a: assert property ( // R7 R10
    clk_en && offset_load
    |=> s.ae_off == $past(ae_offset_in) && s.af_off == $past(af_offset_in))
    else $error("offsets not loaded");

  offset_hold_a: assert property ( // R8 R11
    !offset_load |=> $stable(s.ae_off) && $stable(s.af_off))
    else $error("offsets changed without a load");

  ae_rise_a: assert property ( // R7 R9
    clk_en && !offset_load && wr_go && !rd_go && level == s.ae_off
    |=> almost_empty_indicator_n)
    else $error("almost-empty flag not raised above offset");

  ae_fall_a: assert property ( // R7 R9
    clk_en && !offset_load && rd_go && !wr_go && level == s.ae_off + 1'b1
    |=> !almost_empty_indicator_n)
    else $error("almost-empty flag not lowered at offset");

  af_fall_a: assert property ( // R10 R12
    clk_en && !offset_load && wr_go && !rd_go
    && (PW+1)'(DEPTH) - level == s.af_off + 1'b1 |=> !almost_full_indicator_n)
    else $error("almost-full flag not lowered at offset");

  af_rise_a: assert property ( // R10 R12
    clk_en && !offset_load && rd_go && !wr_go
    && (PW+1)'(DEPTH) - level == s.af_off |=> almost_full_indicator_n)
    else $error("almost-full flag not raised above offset");

  oe_drive_a: assert property ( // R3
    !output_enable_n |-> read_data_oe && read_data_out == s.q)
    else $error("output bus not driven while enabled");

  first_write_latency_a: assert property ( // R6
    clk_en && level == '0 && wr_go |=> !empty_indicator_n)
    else $error("empty flag raised before the word reached the output");

  second_edge_clears_a: assert property ( // R6
    clk_en && level == '0 && wr_go ##1 clk_en |=> empty_indicator_n)
    else $error("empty flag not raised two edges after first write");

  refill_keeps_word_a: assert property ( // R6
    clk_en && rd_go && s.mem_cnt != '0 |=> empty_indicator_n)
    else $error("empty flag lowered with words still stored");

  full_no_growth_a: assert property ( // R13
    clk_en && !full_indicator_n |=> s.mem_cnt <= $past(s.mem_cnt))
    else $error("storage grew while full");

  refused_read_keeps_a: assert property ( // R2
    clk_en && !empty_indicator_n |=> s.buf_cnt >= $past(s.buf_cnt))
    else $error("output buffer drained while empty");
endmodule // fifo_read_port_and_status_flags
`default_nettype wire

// ===== word_source.sv
// producer model on the write side: writes words 0,1,2.. until taken reaches want
// assumes the bench changes want away from the rising edge
`timescale 1ns/1ns
`default_nettype none
module word_source (
  input wire logic clk_sys,
  input wire logic full_indicator_n,
  input wire logic [6:0] want,
  output logic [8:0] write_data_in,
  output logic write_enable_a_n,
  output logic write_enable_b_or_offset_load,
  output int taken
);
  int n;
  initial begin
    taken = 0;
    write_enable_a_n = 1'b1;
    write_enable_b_or_offset_load = 1'b0;
    write_data_in = 9'h000;
  end
  always @(posedge clk_sys) begin
    n = taken + int'(!write_enable_a_n && full_indicator_n);
    taken <= n;
    write_enable_a_n <= !(n < want);
    write_enable_b_or_offset_load <= n < want;
    // idle data inverted so a stale word never looks valid
    write_data_in <= (n < want) ? n[8:0] : ~n[8:0];
  end
endmodule // word_source
`default_nettype wire

// ===== test_fifo_read_port_and_status_flags.sv
// self-checking bench for the fifo read port and status flags
// assumes word_source as producer; bench inputs move on the falling edge, word_source outputs on the rising edge
`timescale 1ns/1ns
`default_nettype none
module test_fifo_read_port_and_status_flags;
  import fifo_status_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b1;
  logic clk_en = 1'b1;
  logic offset_load = 1'b0;
  logic [6:0] ae_off_in = 7'h00;
  logic [6:0] af_off_in = 7'h00;
  logic read_enable_a_n = 1'b1;
  logic read_enable_b_n = 1'b1;
  logic output_enable_n = 1'b0;
  logic [6:0] want = 7'h00;
  logic [8:0] write_data_in, read_data_out;
  logic write_enable_a_n, write_enable_b_or_offset_load, read_data_oe;
  wire flags_s fl;
  int taken;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  wire [8:0] q_bus = read_data_oe ? read_data_out : 9'bz;
  always #50 clk_sys = ~clk_sys;
  word_source src (.clk_sys, .full_indicator_n(fl.full_n), .want, .write_data_in,
    .write_enable_a_n, .write_enable_b_or_offset_load, .taken);
  fifo_read_port_and_status_flags DUT (.clk_sys, .rst_n, .clk_en, .write_data_in,
    .write_enable_a_n, .write_enable_b_or_offset_load, .offset_load,
    .ae_offset_in(ae_off_in), .af_offset_in(af_off_in), .read_enable_a_n, .read_enable_b_n,
    .output_enable_n, .read_data_out, .read_data_oe, .full_indicator_n(fl.full_n),
    .almost_full_indicator_n(fl.almost_full_n), .empty_indicator_n(fl.empty_n),
    .almost_empty_indicator_n(fl.almost_empty_n));
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic fill_to(input logic [6:0] n, input logic [3:0] exp);
    want = n;
    for (int i = 0; i < 300 && taken < n; i++) @(negedge clk_sys);
    repeat (3) @(negedge clk_sys);
    chk({5'h00, fl}, {5'h00, exp});
  endtask
  task automatic one_read(input logic a_n, input logic b_n, input logic [8:0] exp);
    read_enable_a_n = a_n;
    read_enable_b_n = b_n;
    @(negedge clk_sys);
    read_enable_a_n = 1'b1;
    read_enable_b_n = 1'b1;
    chk(read_data_out, exp);
  endtask
  task automatic drain(input int n);
    read_enable_a_n = 1'b0;
    read_enable_b_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      @(negedge clk_sys);
      chk(read_data_out, 9'(i));
    end
    read_enable_a_n = 1'b1;
    read_enable_b_n = 1'b1;
  endtask
  task automatic tristate;
    output_enable_n = 1'b1;
    #1 chk(q_bus, 9'bz);
    @(negedge clk_sys);
    output_enable_n = 1'b0;
    #1 chk(q_bus, 9'h040);
    @(negedge clk_sys);
  endtask
  task automatic load_offsets(input logic [6:0] ae, input logic [6:0] af);
    ae_off_in = ae;
    af_off_in = af;
    offset_load = 1'b1;
    @(negedge clk_sys);
    offset_load = 1'b0;
  endtask
  task automatic frozen_read(input logic [8:0] exp, input logic [3:0] flags);
    clk_en = 1'b0;
    read_enable_a_n = 1'b0;
    read_enable_b_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    read_enable_a_n = 1'b1;
    read_enable_b_n = 1'b1;
    clk_en = 1'b1;
    chk(read_data_out, exp);
    chk({5'h00, fl}, {5'h00, flags});
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    // far above the roughly 470 cycles the sequence needs
    if (cyc == 3000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    rst_n = 1'b0;
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    chk({5'h00, fl}, 9'h00c);
    fill_to(7'd7, 4'b1110);
    fill_to(7'd8, 4'b1111);
    one_read(1'b0, 1'b1, 9'h000);
    one_read(1'b1, 1'b0, 9'h000);
    fill_to(7'd57, 4'b1011);
    fill_to(7'd64, 4'b0011);
    fill_to(7'd65, 4'b0011);
    chk(taken[8:0], 9'h040);
    drain(65);
    chk({5'h00, fl}, 9'h00c);
    one_read(1'b0, 1'b0, 9'h040);
    tristate();
    load_offsets(7'h02, 7'h3e);
    fill_to(7'd68, 4'b1011);
    frozen_read(9'h040, 4'b1011);
    one_read(1'b0, 1'b0, 9'h041);
    chk({5'h00, fl}, 9'h00a);
    conclude();
  end
endmodule // test_fifo_read_port_and_status_flags
`default_nettype wire
